// ### plc_pkg.sv
// register map, reset values and carrier types of the line control bank
package plc_pkg;

    // -----------------------------------------------------------------
    // widths
    // -----------------------------------------------------------------
    localparam int LINES = 32;
    localparam int ADDR_W = 8;

    // -----------------------------------------------------------------
    // register byte offsets
    // -----------------------------------------------------------------
    localparam logic [7:0] OFS_OWN_ENABLE = 8'h00;
    localparam logic [7:0] OFS_OWN_DISABLE = 8'h04;
    localparam logic [7:0] OFS_OWN_STATUS = 8'h08;
    localparam logic [7:0] OFS_DRV_ENABLE = 8'h10;
    localparam logic [7:0] OFS_DRV_DISABLE = 8'h14;
    localparam logic [7:0] OFS_DRV_STATUS = 8'h18;
    localparam logic [7:0] OFS_FLT_ENABLE = 8'h20;
    localparam logic [7:0] OFS_FLT_DISABLE = 8'h24;
    localparam logic [7:0] OFS_FLT_STATUS = 8'h28;
    localparam logic [7:0] OFS_VAL_SET = 8'h30;
    localparam logic [7:0] OFS_VAL_CLEAR = 8'h34;
    localparam logic [7:0] OFS_VAL_READBACK = 8'h38;
    localparam logic [7:0] OFS_PAD_SAMPLE = 8'h3c;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h40;
    localparam logic [7:0] OFS_IRQ_DISABLE = 8'h44;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h48;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h4c;
    localparam logic [7:0] OFS_DWR_ENABLE = 8'ha0;
    localparam logic [7:0] OFS_DWR_DISABLE = 8'ha4;
    localparam logic [7:0] OFS_DWR_STATUS = 8'ha8;

    // -----------------------------------------------------------------
    // reset values
    // -----------------------------------------------------------------
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    // ownership reset is product dependent; this default is arbitrary
    localparam logic [31:0] RST_OWN_DEFAULT = 32'hffff_ffff;

    // -----------------------------------------------------------------
    // carrier types
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [31:0] level;
        logic [31:0] enable;
    } plc_pad_drive_t;

endpackage

// ### plc_line_bank.sv
// 32-line parallel i/o control bank with apb register access
//
// The implementer's own choices: the address map and the APB register port.

// Function
// - ownership status reads 1 where the controller drives, 0 for peripheral.
// - a one written to driver enable turns that line's driver on.
// - a one written to driver disable makes that line input only.
// - driver status reads 1 for driven lines, 0 for pure inputs.
// - a one written to filter enable activates that line's glitch filter.
// - a one written to filter disable deactivates that line's glitch filter.
// - filter status reads 1 where the glitch filter is active.
// - a one written to value set makes that line's drive value 1.
// - a one written to value clear makes that line's drive value 0.
// - readback returns the stored drive values, not the pad levels.
// - readback acts read-only or writable, per line.
// - direct readback writes only change lines enabled in direct write status.
// - pad sample returns each pad's sampled level whatever owner or direction.
// - pad sampling updates only while the clock runs; otherwise holds.
// - a one written to interrupt enable enables that line's change interrupt.
// - filter status resets to all zeros.
module plc_line_bank
#(
    parameter logic [31:0] OWN_RESET = plc_pkg::RST_OWN_DEFAULT
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [plc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic [plc_pkg::LINES-1:0] pad_in,
    input wire plc_pkg::plc_pad_drive_t periph_drive,
    output plc_pkg::plc_pad_drive_t pad_drive
);
    import plc_pkg::*;

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    logic [31:0] line_ownership_status;
    logic [31:0] output_driver_status;
    logic [31:0] glitch_filter_status;
    logic [31:0] drive_value_readback;
    logic [31:0] direct_write_status;
    logic [31:0] change_irq_mask;
    logic [31:0] change_irq_status;
    logic [31:0] pad_sync1;
    logic [31:0] pad_level_sample;
    logic [31:0] pad_prev;
    logic [31:0] filtered;
    logic [31:0] filtered_prev;

    // -----------------------------------------------------------------
    // apb handshake and decode
    // -----------------------------------------------------------------
    // one wait state: pready rises in the second access cycle
    logic access;
    logic commit;
    logic wr;
    logic rd_start;
    assign access = psel & penable;
    assign commit = access & pready;
    assign wr = commit & pwrite;
    assign rd_start = access & ~pready & ~pwrite;

    // per-register hits
    logic hit_own_en, hit_own_dis, hit_own_st;
    logic hit_drv_en, hit_drv_dis, hit_drv_st;
    logic hit_flt_en, hit_flt_dis, hit_flt_st;
    logic hit_val_set, hit_val_clr, hit_val_rb, hit_pad;
    logic hit_irq_en, hit_irq_dis, hit_irq_mask, hit_irq_st;
    logic hit_dwr_en, hit_dwr_dis, hit_dwr_st;
    logic hit_any;
    assign hit_own_en = (paddr == OFS_OWN_ENABLE);
    assign hit_own_dis = (paddr == OFS_OWN_DISABLE);
    assign hit_own_st = (paddr == OFS_OWN_STATUS);
    assign hit_drv_en = (paddr == OFS_DRV_ENABLE);
    assign hit_drv_dis = (paddr == OFS_DRV_DISABLE);
    assign hit_drv_st = (paddr == OFS_DRV_STATUS);
    assign hit_flt_en = (paddr == OFS_FLT_ENABLE);
    assign hit_flt_dis = (paddr == OFS_FLT_DISABLE);
    assign hit_flt_st = (paddr == OFS_FLT_STATUS);
    assign hit_val_set = (paddr == OFS_VAL_SET);
    assign hit_val_clr = (paddr == OFS_VAL_CLEAR);
    assign hit_val_rb = (paddr == OFS_VAL_READBACK);
    assign hit_pad = (paddr == OFS_PAD_SAMPLE);
    assign hit_irq_en = (paddr == OFS_IRQ_ENABLE);
    assign hit_irq_dis = (paddr == OFS_IRQ_DISABLE);
    assign hit_irq_mask = (paddr == OFS_IRQ_MASK);
    assign hit_irq_st = (paddr == OFS_IRQ_STATUS);
    assign hit_dwr_en = (paddr == OFS_DWR_ENABLE);
    assign hit_dwr_dis = (paddr == OFS_DWR_DISABLE);
    assign hit_dwr_st = (paddr == OFS_DWR_STATUS);
    assign hit_any = hit_own_en | hit_own_dis | hit_own_st
        | hit_drv_en | hit_drv_dis | hit_drv_st
        | hit_flt_en | hit_flt_dis | hit_flt_st
        | hit_val_set | hit_val_clr | hit_val_rb | hit_pad
        | hit_irq_en | hit_irq_dis | hit_irq_mask | hit_irq_st
        | hit_dwr_en | hit_dwr_dis | hit_dwr_st;

    // -----------------------------------------------------------------
    // read data selection
    // -----------------------------------------------------------------
    // command registers are absent from the mux, so they read as zero
    logic [31:0] rd_data;
    assign rd_data =
          ({32{hit_own_st}} & line_ownership_status)
        | ({32{hit_drv_st}} & output_driver_status)
        | ({32{hit_flt_st}} & glitch_filter_status)
        | ({32{hit_val_rb}} & drive_value_readback)
        | ({32{hit_pad}} & pad_level_sample)
        | ({32{hit_irq_mask}} & change_irq_mask)
        | ({32{hit_irq_st}} & change_irq_status)
        | ({32{hit_dwr_st}} & direct_write_status);

    // -----------------------------------------------------------------
    // next register values
    // -----------------------------------------------------------------
    // set/clear pairs: a zero bit leaves its line alone
    logic [31:0] w_own_en, w_own_dis, w_drv_en, w_drv_dis;
    logic [31:0] w_flt_en, w_flt_dis, w_set, w_clr, w_rb;
    logic [31:0] w_irq_en, w_irq_dis, w_irq_clr, w_dwr_en, w_dwr_dis;
    assign w_own_en = {32{wr & hit_own_en}} & pwdata;
    assign w_own_dis = {32{wr & hit_own_dis}} & pwdata;
    assign w_drv_en = {32{wr & hit_drv_en}} & pwdata;
    assign w_drv_dis = {32{wr & hit_drv_dis}} & pwdata;
    assign w_flt_en = {32{wr & hit_flt_en}} & pwdata;
    assign w_flt_dis = {32{wr & hit_flt_dis}} & pwdata;
    assign w_set = {32{wr & hit_val_set}} & pwdata;
    assign w_clr = {32{wr & hit_val_clr}} & pwdata;
    assign w_rb = {32{wr & hit_val_rb}} & direct_write_status;
    assign w_irq_en = {32{wr & hit_irq_en}} & pwdata;
    assign w_irq_dis = {32{wr & hit_irq_dis}} & pwdata;
    assign w_irq_clr = {32{wr & hit_irq_st}} & pwdata;
    assign w_dwr_en = {32{wr & hit_dwr_en}} & pwdata;
    assign w_dwr_dis = {32{wr & hit_dwr_dis}} & pwdata;

    logic [31:0] next_val;
    logic [31:0] next_mask;
    logic [31:0] next_irq_st;
    // direct write replaces only enabled lines; set and clear follow
    assign next_val = ((((drive_value_readback & ~w_rb)
        | (pwdata & w_rb)) | w_set) & ~w_clr);

    // -----------------------------------------------------------------
    // enable/disable pairs
    // -----------------------------------------------------------------
    // ownership: enable hands a line to the controller, disable to
    // the peripheral; the reset owner is a build choice
    plc_setclr_reg #(.WIDTH(LINES), .RESET_VALUE(OWN_RESET)) u_own
    (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .set_bits(w_own_en),
        .clr_bits(w_own_dis),
        .q(line_ownership_status),
        .next_q()
    );

    // output driver: lines start as pure inputs; the pad sees a change
    // one edge after the write, through the pad drive flops
    plc_setclr_reg #(.WIDTH(LINES), .RESET_VALUE(RST_ZERO)) u_drv
    (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .set_bits(w_drv_en),
        .clr_bits(w_drv_dis),
        .q(output_driver_status),
        .next_q()
    );

    // glitch filter: every filter starts inactive after reset
    plc_setclr_reg #(.WIDTH(LINES), .RESET_VALUE(RST_ZERO)) u_flt
    (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .set_bits(w_flt_en),
        .clr_bits(w_flt_dis),
        .q(glitch_filter_status),
        .next_q()
    );

    // interrupt mask: the next value is passed on so irq tracks a
    // mask write in the same edge as the status it gates
    plc_setclr_reg #(.WIDTH(LINES), .RESET_VALUE(RST_ZERO)) u_mask
    (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .set_bits(w_irq_en),
        .clr_bits(w_irq_dis),
        .q(change_irq_mask),
        .next_q(next_mask)
    );

    // direct write enable: picks the lines a readback write may change
    plc_setclr_reg #(.WIDTH(LINES), .RESET_VALUE(RST_ZERO)) u_dwr
    (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .set_bits(w_dwr_en),
        .clr_bits(w_dwr_dis),
        .q(direct_write_status),
        .next_q()
    );

    // -----------------------------------------------------------------
    // input path: synchroniser, glitch filter, change detection
    // -----------------------------------------------------------------
    // a filtered line moves only after two equal samples, so a pulse
    // of one clock is rejected; unfiltered lines follow the sample
    logic [31:0] stable;
    logic [31:0] next_filtered;
    logic [31:0] change_evt;
    assign stable = ~(pad_level_sample ^ pad_prev);
    assign next_filtered = (glitch_filter_status
        & ((stable & pad_level_sample) | (~stable & filtered)))
        | (~glitch_filter_status & pad_level_sample);
    assign change_evt = filtered ^ filtered_prev;
    // a change in the clearing cycle keeps its bit set
    assign next_irq_st = (change_irq_status & ~w_irq_clr) | change_evt;

    // pad drive: owned lines use the controller, others the peripheral
    plc_pad_drive_t next_drive;
    assign next_drive.level = (line_ownership_status & drive_value_readback)
        | (~line_ownership_status & periph_drive.level);
    assign next_drive.enable = (line_ownership_status & output_driver_status)
        | (~line_ownership_status & periph_drive.enable);

    // -----------------------------------------------------------------
    // apb response flops
    // -----------------------------------------------------------------
    // read data is latched as pready rises and held for the transfer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= RST_ZERO;
        end
        else if (clk_en)
        begin
            pready <= access & ~pready;
            pslverr <= access & ~pready & ~hit_any;
            if (rd_start)
            begin
                prdata <= rd_data;
            end
        end
    end

    // -----------------------------------------------------------------
    // drive value register
    // -----------------------------------------------------------------
    // set, clear and direct write share one flop so they cannot race
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            drive_value_readback <= RST_ZERO;
        end
        else if (clk_en)
        begin
            drive_value_readback <= next_val;
        end
    end

    // -----------------------------------------------------------------
    // pad sampling
    // -----------------------------------------------------------------
    // clock enable low freezes the sample, as a stopped clock would
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pad_sync1 <= RST_ZERO;
            pad_level_sample <= RST_ZERO;
            pad_prev <= RST_ZERO;
        end
        else if (clk_en)
        begin
            pad_sync1 <= pad_in;
            pad_level_sample <= pad_sync1;
            pad_prev <= pad_level_sample;
        end
    end

    // -----------------------------------------------------------------
    // filter, interrupt status and interrupt line
    // -----------------------------------------------------------------
    // filtered level and its previous copy feed the change detector
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            filtered <= RST_ZERO;
            filtered_prev <= RST_ZERO;
            change_irq_status <= RST_ZERO;
            irq <= 1'b0;
        end
        else if (clk_en)
        begin
            filtered <= next_filtered;
            filtered_prev <= filtered;
            change_irq_status <= next_irq_st;
            irq <= |(next_irq_st & next_mask);
        end
    end

    // -----------------------------------------------------------------
    // pad drive outputs
    // -----------------------------------------------------------------
    // registered so the pads never see decode glitches
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pad_drive <= '0;
        end
        else if (clk_en)
        begin
            pad_drive <= next_drive;
        end
    end

endmodule // plc_line_bank

// -----------------------------------------------------------------
// enable/disable register pair, one bit per line
// -----------------------------------------------------------------
module plc_setclr_reg
#(
    parameter int WIDTH = plc_pkg::LINES,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] set_bits,
    input wire logic [WIDTH-1:0] clr_bits,
    output logic [WIDTH-1:0] q,
    output logic [WIDTH-1:0] next_q
);
    import plc_pkg::*;

    // a zero bit in either command leaves its line alone; set and
    // clear come from different addresses so they never meet
    assign next_q = (q | set_bits) & ~clr_bits;

    // only the constant reset value is loaded asynchronously
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= RESET_VALUE;
        end
        else if (clk_en)
        begin
            q <= next_q;
        end
    end

endmodule // plc_setclr_reg

// ### plc_line_bank_monitor.sv
// port checker for the line control bank
module plc_line_bank_monitor
#(
    parameter logic [31:0] OWN_RESET = plc_pkg::RST_OWN_DEFAULT
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [plc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic [plc_pkg::LINES-1:0] pad_in,
    input wire plc_pkg::plc_pad_drive_t periph_drive,
    input wire plc_pkg::plc_pad_drive_t pad_drive
);
    import plc_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [31:0] own_m;
    logic [31:0] d1;
    logic [31:0] d2;
    logic [31:0] de;
    wire wr = psel && penable && pready && pwrite && clk_en;
    wire rd = psel && penable && pready && !pwrite;
    // ownership mirror: only owned lines follow the bank's registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            own_m <= OWN_RESET;
        else if (wr && paddr == OFS_OWN_ENABLE)
            own_m <= own_m | pwdata;
        else if (wr && paddr == OFS_OWN_DISABLE)
            own_m <= own_m & ~pwdata;
    end
    // write data two edges back, masked to owned lines
    always_ff @(posedge pclk)
    begin
        d1 <= pwdata;
        d2 <= d1 & own_m;
    end
    assign de = d2 & pad_drive.enable;
    a_ready_pulse: assert property (pready && clk_en |=> !pready)
        else $error("pready held past one cycle");
    a_wait_state: assert property (psel && penable && !pready && clk_en
        |=> pready) else $error("pready late");
    a_err_only_ready: assert property (pslverr |-> pready && psel)
        else $error("pslverr outside a transfer");
    a_drv_on: assert property (wr && paddr == OFS_DRV_ENABLE
        |-> ##2 (pad_drive.enable & d2) == d2) else $error("driver on");
    a_drv_off: assert property (wr && paddr == OFS_DRV_DISABLE
        |-> ##2 (pad_drive.enable & d2) == 0) else $error("driver off");
    a_val_set: assert property (wr && paddr == OFS_VAL_SET
        |-> ##2 (pad_drive.level & de) == de) else $error("value set");
    a_val_clear: assert property (wr && paddr == OFS_VAL_CLEAR
        |-> ##2 (pad_drive.level & de) == 0) else $error("value clear");
    a_cmd_read: assert property (rd && (paddr == OFS_DRV_ENABLE
        || paddr == OFS_VAL_SET) |-> prdata == 32'h0000_0000)
        else $error("command read not zero");
    a_owner_read: assert property (rd && paddr == OFS_OWN_STATUS
        |-> prdata == own_m) else $error("ownership readback");
endmodule // plc_line_bank_monitor

bind plc_line_bank plc_line_bank_monitor #(.OWN_RESET(OWN_RESET)) u_mon
    (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .irq, .pad_in, .periph_drive, .pad_drive);

// ### plc_pad_model.sv
// pads and peripheral beside the line control bank
module plc_pad_model
(
    input wire logic pclk,
    input wire logic [31:0] ext,
    input wire logic [31:0] per_en,
    input wire plc_pkg::plc_pad_drive_t pad_drive,
    output logic [31:0] pad_in,
    output plc_pkg::plc_pad_drive_t periph_drive
);
    timeunit 1ns;
    timeprecision 1ns;
    import plc_pkg::*;
    logic [31:0] per_lvl = 32'h5555_5555;
    // peripheral level flips each cycle so a stale copy never matches
    always @(posedge pclk)
        per_lvl <= ~per_lvl;
    assign periph_drive = '{level: per_lvl, enable: per_en};
    // wire level: the bank's driver wins, else the outside level
    assign pad_in = (pad_drive.enable & pad_drive.level)
        | (~pad_drive.enable & ext);
endmodule // plc_pad_model

// ### tb_plc_line_bank.sv
// self-checking bench for the line control bank
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb_plc_line_bank;
    timeunit 1ns;
    timeprecision 1ns;
    import plc_pkg::*;
    logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0;
    logic pwrite = 0, pready, pslverr, irq;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, pad_in;
    logic [31:0] ext = 32'h1234_5600, per_en = 32'h0000_0000;
    plc_pad_drive_t periph_drive, pad_drive;
    int n_errors = 0, tests_run = 0;
    always #25 pclk = ~pclk;
    plc_line_bank dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .pad_in,
        .periph_drive, .pad_drive);
    plc_pad_model u_pads (.pclk, .ext, .per_en, .pad_drive, .pad_in,
        .periph_drive);
    task automatic wait_c(input int k);
        repeat (k) @(posedge pclk);
    endtask
    // one apb transfer; a hung slave is left to the watchdog
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        int waits;
        waits = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            waits++;
        end
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one wait state: pready is seen at the second access edge
        `CHK("pready_wait", 2, waits)
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, string nm);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        `CHK(nm, x, q)
    endtask
    task automatic t_reset;
        logic [31:0] q;
        logic e;
        rd(OFS_OWN_STATUS, RST_OWN_DEFAULT, "own");
        rd(OFS_DRV_STATUS, RST_ZERO, "drv");
        rd(OFS_FLT_STATUS, RST_ZERO, "flt");
        wr(8'h0c, 32'hffff_ffff);
        apb(1'b0, 8'h0c, 32'h0000_0000, q, e);
        `CHK("slverr", 1'b1, e)
        $display("test reset done");
    endtask
    task automatic t_driver;
        wr(OFS_OWN_DISABLE, 32'h0000_0080);
        rd(OFS_OWN_STATUS, 32'hffff_ff7f, "own");
        wr(OFS_DRV_ENABLE, 32'h0000_00ff);
        wr(OFS_DRV_DISABLE, 32'h0000_000f);
        rd(OFS_DRV_STATUS, 32'h0000_00f0, "drv");
        rd(OFS_DRV_ENABLE, RST_ZERO, "cmd");
        per_en <= 32'h0000_0080;
        wait_c(3);
        `CHK("pad_en", 32'h0000_00f0, pad_drive.enable)
        per_en <= 32'h0000_0000;
        $display("test driver done");
    endtask
    task automatic t_filter;
        wr(OFS_FLT_ENABLE, 32'h0000_0003);
        wr(OFS_FLT_DISABLE, 32'h0000_0001);
        rd(OFS_FLT_STATUS, 32'h0000_0002, "flt");
        rd(OFS_FLT_DISABLE, RST_ZERO, "cmd");
        // one-clock pulses: filtered line 1 drops it, line 0 keeps it
        wr(OFS_IRQ_STATUS, 32'hffff_ffff);
        ext <= ext ^ 32'h0000_0003;
        wait_c(1);
        ext <= ext ^ 32'h0000_0003;
        wait_c(6);
        rd(OFS_IRQ_STATUS, 32'h0000_0001, "glitch");
        $display("test filter done");
    endtask
    task automatic t_value;
        wr(OFS_VAL_SET, 32'h0000_00a5);
        wr(OFS_VAL_CLEAR, 32'h0000_0005);
        rd(OFS_VAL_READBACK, 32'h0000_00a0, "val");
        wr(OFS_VAL_READBACK, 32'h0000_00ff);
        rd(OFS_VAL_READBACK, 32'h0000_00a0, "val_ro");
        wr(OFS_DWR_ENABLE, 32'h0000_000f);
        wr(OFS_VAL_READBACK, 32'h0000_00ff);
        rd(OFS_VAL_READBACK, 32'h0000_00af, "val_rw");
        wait_c(4);
        rd(OFS_PAD_SAMPLE, (ext & ~32'h0000_0070) | 32'h0000_0020,
            "pad");
        $display("test value done");
    endtask
    task automatic t_irq;
        wr(OFS_IRQ_STATUS, 32'hffff_ffff);
        wr(OFS_IRQ_ENABLE, 32'h0000_0100);
        rd(OFS_IRQ_MASK, 32'h0000_0100, "mask");
        ext <= ext ^ 32'h0000_0100;
        wait_c(6);
        `CHK("irq", 1'b1, irq)
        rd(OFS_IRQ_STATUS, 32'h0000_0100, "stat");
        wr(OFS_IRQ_STATUS, 32'h0000_0100);
        wr(OFS_IRQ_DISABLE, 32'h0000_0100);
        ext <= ext ^ 32'h0000_0100;
        wait_c(6);
        `CHK("irq_masked", 1'b0, irq)
        wr(OFS_IRQ_STATUS, 32'hffff_ffff);
        // a pad pulse while the clock is held must leave no trace
        clk_en <= 1'b0;
        ext <= ext ^ 32'h0000_0200;
        wait_c(4);
        ext <= ext ^ 32'h0000_0200;
        wait_c(4);
        clk_en <= 1'b1;
        wait_c(6);
        rd(OFS_IRQ_STATUS, RST_ZERO, "frozen");
        $display("test irq done");
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        wait_c(8);
        presetn <= 1'b1;
        t_reset;
        t_driver;
        t_filter;
        t_value;
        t_irq;
        conclude;
    end
    // watchdog well beyond the under two hundred cycles the run takes
    initial
    begin
        #100000;
        n_errors++;
        conclude;
    end
endmodule // tb_plc_line_bank
